// >>> tmr_pkg.sv
/*
  Package of the 8-bit timer with compare modulator: register offsets,
  field positions, reset values and mode encodings.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package tmr_pkg;

  // Register byte offsets
  localparam logic [7:0] TMR_OFS_CONTROL   = 8'h00;
  localparam logic [7:0] TMR_OFS_COUNTER   = 8'h04;
  localparam logic [7:0] TMR_OFS_COMPARE   = 8'h08;
  localparam logic [7:0] TMR_OFS_IRQ_MASK  = 8'h0c;
  localparam logic [7:0] TMR_OFS_IRQ_FLAGS = 8'h10;
  localparam logic [7:0] TMR_OFS_PIN_CFG   = 8'h14;

  // Control register fields
  localparam int TMR_CTL_FORCE    = 7;
  localparam int TMR_CTL_WAVE0    = 6;
  localparam int TMR_CTL_MODE_HI  = 5;
  localparam int TMR_CTL_MODE_LO  = 4;
  localparam int TMR_CTL_WAVE1    = 3;
  localparam int TMR_CTL_SRC_HI   = 2;
  localparam int TMR_CTL_SRC_LO   = 0;

  // Interrupt mask and flag bits
  localparam int TMR_BIT_COMPARE  = 7;
  localparam int TMR_BIT_OVERFLOW = 6;

  // Shared pin configuration bits
  localparam int TMR_PIN_PORT_BIT = 0;
  localparam int TMR_PIN_DIR_BIT  = 1;

  // Reset values
  localparam logic [7:0] TMR_RST_BYTE = 8'h00;
  localparam logic [1:0] TMR_RST_PIN  = 2'h0;

  // Counter limits
  localparam logic [7:0] TMR_BOTTOM = 8'h00;
  localparam logic [7:0] TMR_MAX    = 8'hff;

  // Prescaler taps: all ones at the tap marks one divided tick
  localparam logic [9:0] TMR_TAP_DIV8    = 10'h007;
  localparam logic [9:0] TMR_TAP_DIV64   = 10'h03f;
  localparam logic [9:0] TMR_TAP_DIV256  = 10'h0ff;
  localparam logic [9:0] TMR_TAP_DIV1024 = 10'h3ff;

  typedef enum logic [2:0] {
    TMR_SRC_STOP    = 3'h0,
    TMR_SRC_DIV1    = 3'h1,
    TMR_SRC_DIV8    = 3'h2,
    TMR_SRC_DIV64   = 3'h3,
    TMR_SRC_DIV256  = 3'h4,
    TMR_SRC_DIV1024 = 3'h5,
    TMR_SRC_EXT_FALL = 3'h6,
    TMR_SRC_EXT_RISE = 3'h7
  } tmr_src_type;

  typedef enum logic [1:0] {
    TMR_WAVE_NORMAL = 2'h0,
    TMR_WAVE_PHASE  = 2'h1,
    TMR_WAVE_CTC    = 2'h2,
    TMR_WAVE_FAST   = 2'h3
  } tmr_wave_type;

endpackage

// >>> tmr_timer.sv
/*
  8-bit timer/counter with clock select, compare unit, overflow and
  compare flags, and the compare modulator on the shared output pin.
  Assumes an APB master on clk_sys_in, synchronous pin inputs, and the
  modulating compare output and its enable from the 16-bit timer.
*/
// Local design decisions: the APB slave port and the register addresses.
// Overview of operation
// - Source code picks stop, undivided or prescaled clock
// - Top two codes count external pin edges
// - External pin counts even when driven as output
// - Counter value is readable and writable
// - Counter write blocks match on next tick
// - Compare value continuously matched against counter
// - Compare enable gates compare flag onto interrupt
// - Overflow enable gates overflow flag onto interrupt
// - Compare flag set on match, vector or W1C
// - Overflow flag set on overflow, vector or W1C
// - Active compare output overrides port data bit
// - Both outputs active enables modulator automatically
// - Port data bit selects AND or OR
// - Direction bit alone enables pin driver
// - Legacy mode disables the modulator
// - Modulated resolution limited by carrier period
// - Zero mode field gives pin to port bit, or to modulating output when active
`timescale 1ns/10ps

module tmr_timer (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Interrupt and vector acknowledge
  input  wire logic        compare_vector_ack_in,
  input  wire logic        overflow_vector_ack_in,
  output logic             irq_out,
  // External count pin level
  input  wire logic        external_count_pin_in,
  // Modulating compare output of the 16-bit timer
  input  wire logic        modulating_compare_output_in,
  input  wire logic        modulating_mode_active_in,
  input  wire logic        legacy_mode_in,
  // Shared output pin
  output logic             shared_output_pin_out,
  output logic             shared_output_pin_oe_out,
  output logic             carrier_compare_output_out
);

  function automatic logic is_pwm(input logic [1:0] wave);
    is_pwm = (wave == tmr_pkg::TMR_WAVE_PHASE) ||
             (wave == tmr_pkg::TMR_WAVE_FAST);
  endfunction

  logic [7:0]  control_q;
  logic [7:0]  counter_q;
  logic [7:0]  compare_buf_q;
  logic [7:0]  compare_act_q;
  logic [7:0]  irq_mask_q;
  logic [7:0]  irq_flags_q;
  logic [1:0]  pin_cfg_q;
  logic [9:0]  presc_q;
  logic        ext_prev_q;
  logic        block_q;
  logic        down_q;
  logic        wave_q;
  logic        ready_q;

  logic        apb_access;
  logic        apb_write;
  logic        apb_read;
  logic        addr_ok;
  logic        tick;
  logic [1:0]  wave_mode;
  logic [1:0]  out_mode;
  logic [2:0]  src;
  logic        at_max;
  logic        match_hit;
  logic        match_ev;
  logic        ovf_ev;
  logic        force_ev;
  logic        wr_counter;
  logic        wr_flags;
  logic [31:0] rdata;

  assign wave_mode = {control_q[tmr_pkg::TMR_CTL_WAVE1],
                      control_q[tmr_pkg::TMR_CTL_WAVE0]};
  assign out_mode  = control_q[tmr_pkg::TMR_CTL_MODE_HI:
                               tmr_pkg::TMR_CTL_MODE_LO];
  assign src       = control_q[tmr_pkg::TMR_CTL_SRC_HI:
                               tmr_pkg::TMR_CTL_SRC_LO];

  // One wait state: pready rises the cycle after the access phase starts
  assign apb_access = psel_in && penable_in && ready_q;
  assign apb_write  = apb_access && pwrite_in;
  assign apb_read   = apb_access && !pwrite_in;
  assign wr_counter = apb_write && (paddr_in == tmr_pkg::TMR_OFS_COUNTER);
  assign wr_flags   = apb_write && (paddr_in == tmr_pkg::TMR_OFS_IRQ_FLAGS);
  assign force_ev   = apb_write && (paddr_in == tmr_pkg::TMR_OFS_CONTROL) &&
                      pwdata_in[tmr_pkg::TMR_CTL_FORCE];

  always_comb begin
    addr_ok = 1'b1;
    rdata   = 32'h0000_0000;
    case (paddr_in)
      tmr_pkg::TMR_OFS_CONTROL:
        rdata[6:0] = control_q[6:0];  // Force strobe reads zero
      tmr_pkg::TMR_OFS_COUNTER:   rdata[7:0] = counter_q;
      tmr_pkg::TMR_OFS_COMPARE:   rdata[7:0] = compare_buf_q;
      tmr_pkg::TMR_OFS_IRQ_MASK:  rdata[7:0] = irq_mask_q;
      tmr_pkg::TMR_OFS_IRQ_FLAGS: rdata[7:0] = irq_flags_q;
      tmr_pkg::TMR_OFS_PIN_CFG:   rdata[1:0] = pin_cfg_q;
      default:                    addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ready_q     <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      ready_q     <= psel_in && penable_in && !ready_q;
      pslverr_out <= psel_in && penable_in && !ready_q && !addr_ok;
      if (psel_in && penable_in && !ready_q && !pwrite_in) begin
        prdata_out <= rdata;
      end
    end
  end

  assign pready_out = ready_q;

  // Plain configuration registers
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      control_q     <= tmr_pkg::TMR_RST_BYTE;
      compare_buf_q <= tmr_pkg::TMR_RST_BYTE;
      irq_mask_q    <= tmr_pkg::TMR_RST_BYTE;
      pin_cfg_q     <= tmr_pkg::TMR_RST_PIN;
    end else if (apb_write) begin
      case (paddr_in)
        tmr_pkg::TMR_OFS_CONTROL: begin
          control_q <= {1'b0, pwdata_in[6:0]};
        end
        tmr_pkg::TMR_OFS_COMPARE:  compare_buf_q <= pwdata_in[7:0];
        tmr_pkg::TMR_OFS_IRQ_MASK: begin
          irq_mask_q <= 8'h00;
          irq_mask_q[tmr_pkg::TMR_BIT_COMPARE] <=
            pwdata_in[tmr_pkg::TMR_BIT_COMPARE];
          irq_mask_q[tmr_pkg::TMR_BIT_OVERFLOW] <=
            pwdata_in[tmr_pkg::TMR_BIT_OVERFLOW];
        end
        tmr_pkg::TMR_OFS_PIN_CFG:  pin_cfg_q <= pwdata_in[1:0];
        default: begin
        end
      endcase
    end
  end

  // Free-running prescaler shared by all divided sources
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      presc_q    <= 10'h000;
      ext_prev_q <= 1'b0;
    end else begin
      presc_q    <= presc_q + 10'h001;
      ext_prev_q <= external_count_pin_in;
    end
  end

  // Pin level is read whatever its direction, so software can count
  always_comb begin
    case (src)
      tmr_pkg::TMR_SRC_STOP:    tick = 1'b0;
      tmr_pkg::TMR_SRC_DIV1:    tick = 1'b1;
      tmr_pkg::TMR_SRC_DIV8:
        tick = (presc_q[2:0] == tmr_pkg::TMR_TAP_DIV8[2:0]);
      tmr_pkg::TMR_SRC_DIV64:
        tick = (presc_q[5:0] == tmr_pkg::TMR_TAP_DIV64[5:0]);
      tmr_pkg::TMR_SRC_DIV256:
        tick = (presc_q[7:0] == tmr_pkg::TMR_TAP_DIV256[7:0]);
      tmr_pkg::TMR_SRC_DIV1024:
        tick = (presc_q == tmr_pkg::TMR_TAP_DIV1024);
      tmr_pkg::TMR_SRC_EXT_FALL:
        tick = ext_prev_q && !external_count_pin_in;
      tmr_pkg::TMR_SRC_EXT_RISE:
        tick = !ext_prev_q && external_count_pin_in;
      default:                  tick = 1'b0;
    endcase
  end

  assign at_max    = (counter_q == tmr_pkg::TMR_MAX);
  assign match_hit = (counter_q == compare_act_q);
  assign match_ev  = tick && match_hit && !block_q;

  // Overflow at MAX, or at the reversal at zero in phase correct PWM
  always_comb begin
    if (wave_mode == tmr_pkg::TMR_WAVE_PHASE) begin
      ovf_ev = tick && down_q &&
               (counter_q == tmr_pkg::TMR_BOTTOM);
    end else begin
      ovf_ev = tick && at_max;
    end
  end

  // Counter write wins over a tick in the same cycle
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      counter_q <= tmr_pkg::TMR_RST_BYTE;
      down_q    <= 1'b0;
    end else if (wr_counter) begin
      counter_q <= pwdata_in[7:0];
    end else if (tick) begin
      case (wave_mode)
        tmr_pkg::TMR_WAVE_CTC: begin
          counter_q <= match_hit ? tmr_pkg::TMR_BOTTOM
                                 : counter_q + 8'h01;
        end
        tmr_pkg::TMR_WAVE_PHASE: begin
          if (!down_q && at_max) begin
            down_q    <= 1'b1;
            counter_q <= counter_q - 8'h01;
          end else if (down_q && counter_q == tmr_pkg::TMR_BOTTOM) begin
            down_q    <= 1'b0;
            counter_q <= counter_q + 8'h01;
          end else begin
            counter_q <= down_q ? counter_q - 8'h01 : counter_q + 8'h01;
          end
        end
        default: counter_q <= counter_q + 8'h01;
      endcase
    end
  end

  // Blocking lasts until the first tick after the counter write
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      block_q <= 1'b0;
    end else if (wr_counter) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // PWM modes take a new compare value only at MAX to avoid glitches
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      compare_act_q <= tmr_pkg::TMR_RST_BYTE;
    end else if (!is_pwm(wave_mode) || (tick && at_max)) begin
      compare_act_q <= compare_buf_q;
    end
  end

  // Waveform of the carrier compare output
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wave_q <= 1'b0;
    end else begin
      case (wave_mode)
        tmr_pkg::TMR_WAVE_FAST: begin
          if (tick && at_max && out_mode[1]) begin
            wave_q <= !out_mode[0];
          end else if (match_ev && out_mode[1]) begin
            wave_q <= out_mode[0];
          end
        end
        tmr_pkg::TMR_WAVE_PHASE: begin
          if (match_ev && out_mode[1]) begin
            wave_q <= down_q ? !out_mode[0] : out_mode[0];
          end
        end
        default: begin
          if (match_ev || force_ev) begin
            case (out_mode)
              2'h1:    wave_q <= !wave_q;
              2'h2:    wave_q <= 1'b0;
              2'h3:    wave_q <= 1'b1;
              default: wave_q <= wave_q;
            endcase
          end
        end
      endcase
    end
  end

  // Hardware set wins over a vector or software clear
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_flags_q <= tmr_pkg::TMR_RST_BYTE;
    end else begin
      if (match_ev) begin
        irq_flags_q[tmr_pkg::TMR_BIT_COMPARE] <= 1'b1;
      end else if (compare_vector_ack_in ||
                   (wr_flags && pwdata_in[tmr_pkg::TMR_BIT_COMPARE])) begin
        irq_flags_q[tmr_pkg::TMR_BIT_COMPARE] <= 1'b0;
      end
      if (ovf_ev) begin
        irq_flags_q[tmr_pkg::TMR_BIT_OVERFLOW] <= 1'b1;
      end else if (overflow_vector_ack_in ||
                   (wr_flags && pwdata_in[tmr_pkg::TMR_BIT_OVERFLOW])) begin
        irq_flags_q[tmr_pkg::TMR_BIT_OVERFLOW] <= 1'b0;
      end
    end
  end

  // Global enable lives in the processor core, outside this block
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (irq_flags_q[tmr_pkg::TMR_BIT_COMPARE] &&
                  irq_mask_q[tmr_pkg::TMR_BIT_COMPARE]) ||
                 (irq_flags_q[tmr_pkg::TMR_BIT_OVERFLOW] &&
                  irq_mask_q[tmr_pkg::TMR_BIT_OVERFLOW]);
    end
  end

  // Shared pin: combining runs at system clock rate, so the modulated
  // waveform only resolves whole carrier periods
  logic carrier_on;
  logic port_bit;
  logic pin_value;

  assign carrier_on = (out_mode != 2'h0);
  assign port_bit   = pin_cfg_q[tmr_pkg::TMR_PIN_PORT_BIT];

  always_comb begin
    if (carrier_on && modulating_mode_active_in && !legacy_mode_in) begin
      pin_value = port_bit ?
        (wave_q || modulating_compare_output_in) :
        (wave_q && modulating_compare_output_in);
    end else if (carrier_on) begin
      pin_value = wave_q;
    end else if (modulating_mode_active_in) begin
      pin_value = modulating_compare_output_in;
    end else begin
      pin_value = port_bit;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      shared_output_pin_out      <= 1'b0;
      shared_output_pin_oe_out   <= 1'b0;
      carrier_compare_output_out <= 1'b0;
    end else begin
      shared_output_pin_out      <= pin_value;
      shared_output_pin_oe_out   <=
        pin_cfg_q[tmr_pkg::TMR_PIN_DIR_BIT];
      carrier_compare_output_out <= wave_q;
    end
  end

endmodule // tmr_timer

// >>> tmr_timer_asserts.sv
/* Port checker of the 8-bit timer with compare modulator.
   Bound to tmr_timer by the bench; sees only the top ports. */
`timescale 1ns/10ps
module tmr_timer_asserts (
  // Clock, reset and APB
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Interrupt and shared pin
  input wire logic        irq_out,
  input wire logic        modulating_compare_output_in,
  input wire logic        modulating_mode_active_in,
  input wire logic        legacy_mode_in,
  input wire logic        shared_output_pin_out,
  input wire logic        shared_output_pin_oe_out,
  input wire logic        carrier_compare_output_out
);
  logic       wr;
  logic [1:0] mode_q;
  logic [1:0] mask_q;
  logic       port_q;

  // Shadow of the written fields, since they are not ports
  assign wr = psel_in && penable_in && pready_out && pwrite_in;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q <= 2'h0;
      mask_q <= 2'h0;
      port_q <= 1'b0;
    end else if (wr) begin
      if (paddr_in == tmr_pkg::TMR_OFS_CONTROL)
        mode_q <= pwdata_in[5:4];
      if (paddr_in == tmr_pkg::TMR_OFS_IRQ_MASK)
        mask_q <= pwdata_in[7:6];
      if (paddr_in == tmr_pkg::TMR_OFS_PIN_CFG)
        port_q <= pwdata_in[0];
    end
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence apb_setup;
    psel_in && !penable_in;
  endsequence
  sequence apb_access;
    psel_in && penable_in;
  endsequence

  ready_wait_a: assert property (apb_setup ##1 apb_access |=> pready_out)
    else $error("pready late");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  err_unmapped_a: assert property (pready_out &&
      paddr_in > tmr_pkg::TMR_OFS_PIN_CFG |-> pslverr_out)
    else $error("unmapped access not refused");
  oe_dir_a: assert property (wr &&
      paddr_in == tmr_pkg::TMR_OFS_PIN_CFG
      |=> ##1 shared_output_pin_oe_out == $past(pwdata_in[1], 2))
    else $error("pin enable differs from direction bit");
  pin_port_a: assert property (mode_q == 2'h0 &&
      !modulating_mode_active_in |=> shared_output_pin_out == $past(port_q))
    else $error("pin not under port control");
  pin_mod_only_a: assert property (mode_q == 2'h0 &&
      modulating_mode_active_in
      |=> shared_output_pin_out == $past(modulating_compare_output_in))
    else $error("pin not the modulating output");
  pin_combine_a: assert property (mode_q != 2'h0 &&
      modulating_mode_active_in && !legacy_mode_in
      |=> shared_output_pin_out == ($past(port_q) ?
      carrier_compare_output_out | $past(modulating_compare_output_in) :
      carrier_compare_output_out & $past(modulating_compare_output_in)))
    else $error("modulated pin value wrong");
  pin_carrier_a: assert property (mode_q != 2'h0 &&
      (legacy_mode_in || !modulating_mode_active_in)
      |=> shared_output_pin_out == carrier_compare_output_out)
    else $error("pin not the carrier output");
  irq_mask_a: assert property (irq_out |-> $past(mask_q) != 2'h0)
    else $error("interrupt with both enables clear");
endmodule // tmr_timer_asserts

// >>> tmr_timer_bench.sv
/* Self-checking bench of tmr_timer: APB master, pin stimulus.
   Assumes tmr_pkg and the checker are compiled before it. */
`timescale 1ns/10ps
module tmr_timer_bench;
  localparam logic [7:0] CTL = tmr_pkg::TMR_OFS_CONTROL;
  localparam logic [7:0] CNT = tmr_pkg::TMR_OFS_COUNTER;
  localparam logic [7:0] CMP = tmr_pkg::TMR_OFS_COMPARE;
  localparam logic [7:0] MSK = tmr_pkg::TMR_OFS_IRQ_MASK;
  localparam logic [7:0] FLG = tmr_pkg::TMR_OFS_IRQ_FLAGS;
  localparam logic [7:0] PIN = tmr_pkg::TMR_OFS_PIN_CFG;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic        err;
  } tmr_row_type;

  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic        compare_vector_ack_in = 1'b0;
  logic        overflow_vector_ack_in = 1'b0;
  logic        external_count_pin_in = 1'b0;
  logic        modulating_compare_output_in = 1'b0;
  logic        modulating_mode_active_in = 1'b0;
  logic        legacy_mode_in = 1'b0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        irq_out;
  logic        shared_output_pin_out;
  logic        shared_output_pin_oe_out;
  logic        carrier_compare_output_out;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  c0;
  logic [7:0]  got;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t0;
  int          lo;
  int          sh [6] = '{0, 0, 3, 6, 8, 10};
  tmr_row_type rows [6] = '{'{CMP, 32'h5a, 32'h5a, 1'b0},
    '{CNT, 32'ha5, 32'ha5, 1'b0}, '{MSK, 32'hff, 32'hc0, 1'b0},
    '{PIN, 32'hff, 32'h03, 1'b0}, '{CTL, 32'h80, 32'h00, 1'b0},
    '{8'h18, 32'hff, 32'h00, 1'b1}};

  tmr_timer i_dut (.*);

  always #25 clk_sys_in = ~clk_sys_in;

  // Whole run needs about 28000 cycles
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Ends one edge after pready so the next setup never collides
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_out !== 1'b1)
      @(posedge clk_sys_in);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_word(nm, e, rd);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    foreach (rows[r]) begin
      wr(rows[r].a, rows[r].d);
      chk_bit("wr_err", rows[r].err, er);
      rdchk("rdata", rows[r].a, rows[r].e);
      chk_bit("rd_err", rows[r].err, er);
    end
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    for (int a = 0; a < 24; a += 4)
      rdchk("reset", 8'(a), 32'h0);
    wr(PIN, 32'h3);
    repeat (2) @(posedge clk_sys_in);
    chk_bit("oe", 1'b1, shared_output_pin_oe_out);
    chk_bit("port_pin", 1'b1, shared_output_pin_out);
    modulating_mode_active_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    chk_bit("mod_pin", 1'b0, shared_output_pin_out);
    wr(CTL, 32'h10);
    for (int i = 0; i < 8; i++) begin
      if (i == 4)
        wr(CTL, 32'h90);
      wr(PIN, {31'h1, i[1]});
      modulating_compare_output_in <= i[0];
      repeat (3) @(posedge clk_sys_in);
      chk_bit("mod_pin", i[1] ? i[2] | i[0] : i[2] & i[0],
        shared_output_pin_out);
      chk_bit("carrier", i[2], carrier_compare_output_out);
    end
    legacy_mode_in <= 1'b1;
    modulating_compare_output_in <= 1'b0;
    wr(PIN, 32'h0);
    repeat (2) @(posedge clk_sys_in);
    chk_bit("legacy_pin", 1'b1, shared_output_pin_out);
    chk_bit("oe", 1'b0, shared_output_pin_oe_out);
    for (int s = 0; s < 6; s++) begin
      wr(CTL, 32'(s));
      apb(1'b0, CNT, 32'h0);
      c0 = rd[7:0];
      t0 = cyc;
      repeat (20 << sh[s]) @(posedge clk_sys_in);
      apb(1'b0, CNT, 32'h0);
      got = rd[7:0] - c0;
      lo = (s == 0) ? 0 : (cyc - t0) >> sh[s];
      chk_bit("ticks", 1'b1, got == lo || (s > 0 && got == lo + 1));
    end
    for (int s = 6; s < 8; s++) begin
      external_count_pin_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      wr(CTL, 32'(s));
      wr(CNT, 32'h0);
      for (int k = 0; k < 3; k++) begin
        external_count_pin_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        if (k < 2)
          external_count_pin_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
      end
      rdchk("ext_count", CNT, (s == 6) ? 2 : 3);
    end
    wr(CTL, 32'h0);
    wr(CMP, 32'h40);
    wr(CNT, 32'h40);
    wr(FLG, 32'hc0);
    wr(CTL, 32'h1);
    rdchk("flags", FLG, 32'h0);
    repeat (300) @(posedge clk_sys_in);
    wr(CTL, 32'h0);
    wr(FLG, 32'h0);
    rdchk("flags", FLG, 32'hc0);
    wr(MSK, 32'h80);
    repeat (2) @(posedge clk_sys_in);
    chk_bit("irq", 1'b1, irq_out);
    wr(FLG, 32'h80);
    rdchk("flags", FLG, 32'h40);
    chk_bit("irq", 1'b0, irq_out);
    wr(MSK, 32'h40);
    repeat (2) @(posedge clk_sys_in);
    chk_bit("irq", 1'b1, irq_out);
    overflow_vector_ack_in <= 1'b1;
    @(posedge clk_sys_in);
    overflow_vector_ack_in <= 1'b0;
    rdchk("flags", FLG, 32'h0);
    chk_bit("irq", 1'b0, irq_out);
    // Match two ticks after start, then the vector clears it
    wr(CNT, 32'h3f);
    wr(CTL, 32'h1);
    wr(CTL, 32'h0);
    rdchk("flags", FLG, 32'h80);
    compare_vector_ack_in <= 1'b1;
    @(posedge clk_sys_in);
    compare_vector_ack_in <= 1'b0;
    rdchk("flags", FLG, 32'h0);
    // Phase PWM: no overflow at the top, only at the turn at zero
    wr(CNT, 32'hf0);
    wr(CTL, 32'h41);
    repeat (40) @(posedge clk_sys_in);
    rdchk("flags", FLG, 32'h0);
    repeat (300) @(posedge clk_sys_in);
    wr(CTL, 32'h0);
    rdchk("flags", FLG, 32'hc0);
    report_and_stop();
  end
endmodule // tmr_timer_bench

bind tmr_timer tmr_timer_asserts i_chk (.*);
